// ---- design/bmiu_core.sv ----
// phase sequenced executor for bit clear, bit set and bit test skip
`default_nettype none
`include "bmiu_defines.svh"
// Contract
// - Words with top bits 01 00 decode as bit clear with index and address.
// - Words with top bits 01 01 decode as bit set with index and address.
// - Words with top bits 01 10 decode as bit test skip if clear.
// - The address spans 0 to 127 and the bit index 0 to 7.
// - Bit clear zeroes the chosen bit and keeps the other seven.
// - Bit set forces the chosen bit to one and keeps the rest.
// - A tested bit of zero turns the next instruction into a no-op.
// - Set and clear run decode, read, modify, write over four phases.
// - Test never writes, and the skipped cycle does nothing at all.
module bmiu_core (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               instr_valid,
  input  wire logic [13:0]        instr_word,
  input  wire logic [7:0]         rf_rdata,
  output var  bmiu_pkg::bmiu_rf_t rf_r,
  output logic                    phase_q1_r,
  output logic                    busy_r,
  output logic                    skip_r,
  output logic                    no_operation_r,
  output logic                    done_r
);
  import bmiu_pkg::*;

  typedef enum logic [2:0] {
    bmiu_idle_s,
    bmiu_q2_s,
    bmiu_q3_s,
    bmiu_q4_s,
    bmiu_n1_s,
    bmiu_n2_s,
    bmiu_n3_s,
    bmiu_n4_s
  } bmiu_state_t;

  bmiu_dec_t   dec;
  bmiu_dec_t   dec_r;
  bmiu_state_t state_r;
  logic [7:0]  data_r;
  logic [7:0]  mask;
  // decisions shared by several flops
  logic        take;      // word accepted on this edge
  logic        skip_hit;  // test found its bit clear in q4
  logic        end_q4;    // q4 that ends the instruction
  logic        wr_go;     // q4 of a set or clear
  // register file port, one flop per concern
  logic        rd_en_r;
  logic        wr_en_r;
  logic [6:0]  addr_r;
  logic [7:0]  wdata_r;

  // q1 decode happens combinationally as the word is taken
  bmiu_decode u_decode (
    .word (instr_word),
    .dec  (dec)
  );

  // one hot bit mask, one index compare per bit lane
  for (genvar i = 0; i < `BMIU_DATA_W; i++) begin : g_mask
    assign mask[i] = (dec_r.bit_idx == 3'(i));
  end

  // shared terms, so every status flop sees the same decision
  always_comb begin
    take     = (state_r == bmiu_idle_s) && instr_valid &&
               (dec.op != bmiu_none_e);
    skip_hit = (state_r == bmiu_q4_s) && (dec_r.op == bmiu_test_e) &&
               !data_r[dec_r.bit_idx];
    end_q4   = (state_r == bmiu_q4_s) && !skip_hit;
    // test reads but never writes back
    wr_go    = (state_r == bmiu_q4_s) && (dec_r.op != bmiu_test_e);
  end

  // phase sequencer, unknown words are ignored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= bmiu_idle_s;
    end else begin
      case (state_r)
        bmiu_idle_s:
          if (instr_valid && dec.op != bmiu_none_e) state_r <= bmiu_q2_s;
        bmiu_q2_s: state_r <= bmiu_q3_s;
        bmiu_q3_s: state_r <= bmiu_q4_s;
        bmiu_q4_s: begin
          // skip appends a full empty cycle
          if (dec_r.op == bmiu_test_e && !data_r[dec_r.bit_idx]) begin
            state_r <= bmiu_n1_s;
          end else begin
            state_r <= bmiu_idle_s;
          end
        end
        bmiu_n1_s: state_r <= bmiu_n2_s;
        bmiu_n2_s: state_r <= bmiu_n3_s;
        bmiu_n3_s: state_r <= bmiu_n4_s;
        bmiu_n4_s: state_r <= bmiu_idle_s;
        default:   state_r <= bmiu_idle_s;
      endcase
    end
  end

  // latch decoded instruction at q1
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dec_r <= '0;
    end else if (state_r == bmiu_idle_s && instr_valid) begin
      dec_r <= dec;
    end
  end

  // read strobe: one pulse just after the take edge, the q2 read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_en_r <= 1'b0;
    end else begin
      rd_en_r <= take;
    end
  end

  // address holds until the next take so a slow reader still sees it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_r <= 7'h00;
    end else if (take) begin
      addr_r <= dec.addr;
    end
  end

  // write strobe only in the cycle after q4, so write and done share one cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_en_r <= 1'b0;
    end else begin
      wr_en_r <= wr_go;
    end
  end

  // the whole modified byte goes back, never a lone bit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wdata_r <= 8'h00;
    end else if (wr_go) begin
      wdata_r <= data_r;
    end
  end

  // register file port is a plain bundle of the four flops above
  always_comb begin
    rf_r.rd_en = rd_en_r;
    rf_r.wr_en = wr_en_r;
    rf_r.addr  = addr_r;
    rf_r.wdata = wdata_r;
  end

  // q2 captures read data, q3 modifies it; test leaves it alone
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_r <= 8'h00;
    end else if (state_r == bmiu_q2_s) begin
      data_r <= rf_rdata;
    end else if (state_r == bmiu_q3_s) begin
      case (dec_r.op)
        bmiu_clear_e: data_r <= data_r & ~mask;
        bmiu_set_e:   data_r <= data_r | mask;
        default:      data_r <= data_r;
      endcase
    end
  end

  // ready in q1 only; a skip keeps it low through the empty cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q1_r <= 1'b1;
    end else begin
      phase_q1_r <= end_q4 || (state_r == bmiu_n4_s) ||
                    (state_r == bmiu_idle_s && !take);
    end
  end

  // busy is the inverse of the ready level so the sequencer may use either
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= !(end_q4 || (state_r == bmiu_n4_s) ||
                  (state_r == bmiu_idle_s && !take));
    end
  end

  // skip pulse tells the sequencer to discard the fetched word
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= skip_hit;
    end
  end

  // all four phases of the discarded cycle do nothing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      no_operation_r <= 1'b0;
    end else begin
      no_operation_r <= skip_hit ||
                        (state_r inside {bmiu_n1_s, bmiu_n2_s, bmiu_n3_s});
    end
  end

  // end pulse after q4, or after the empty cycle of a skip
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= end_q4 || (state_r == bmiu_n4_s);
    end
  end
endmodule : bmiu_core
`default_nettype wire

// ---- design/bmiu_defines.svh ----
// constants for the bit manipulation instruction unit
`ifndef BMIU_DEFINES_SVH
`define BMIU_DEFINES_SVH
`define BMIU_WORD_W      14
`define BMIU_ADDR_W      7
`define BMIU_BIT_W       3
`define BMIU_DATA_W      8
`define BMIU_CLASS_HI    13
`define BMIU_CLASS_LO    12
`define BMIU_CLASS_BIT   2'h1
`define BMIU_OP_HI       11
`define BMIU_OP_LO       10
`define BMIU_OP_CLEAR    2'h0
`define BMIU_OP_SET      2'h1
`define BMIU_OP_TEST     2'h2
`define BMIU_IDX_HI      9
`define BMIU_IDX_LO      7
`define BMIU_ADR_HI      6
`define BMIU_ADR_LO      0
`define BMIU_ADDR_MAX    7'h7f
`define BMIU_BIT_MAX     3'h7
`endif

// ---- design/bmiu_pkg.sv ----
// types for the bit manipulation instruction unit
`default_nettype none
package bmiu_pkg;
  typedef enum logic [1:0] {
    bmiu_none_e,
    bmiu_clear_e,
    bmiu_set_e,
    bmiu_test_e
  } bmiu_op_t;

  typedef struct packed {
    bmiu_op_t   op;
    logic [2:0] bit_idx;
    logic [6:0] addr;
  } bmiu_dec_t;

  // register file access bundle
  typedef struct packed {
    logic       rd_en;
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] wdata;
  } bmiu_rf_t;
endpackage : bmiu_pkg
`default_nettype wire

// ---- design/bmiu_decode.sv ----
// opcode decoder for the three bit instructions
`default_nettype none
`include "bmiu_defines.svh"
module bmiu_decode (
  input  wire logic [13:0]        word,
  output var  bmiu_pkg::bmiu_dec_t dec
);
  import bmiu_pkg::*;

  // field split and opcode match
  always_comb begin
    dec.bit_idx = word[`BMIU_IDX_HI:`BMIU_IDX_LO];
    dec.addr    = word[`BMIU_ADR_HI:`BMIU_ADR_LO];
    dec.op      = bmiu_none_e;
    if (word[`BMIU_CLASS_HI:`BMIU_CLASS_LO] == `BMIU_CLASS_BIT) begin
      case (word[`BMIU_OP_HI:`BMIU_OP_LO])
        `BMIU_OP_CLEAR: dec.op = bmiu_clear_e;
        `BMIU_OP_SET:   dec.op = bmiu_set_e;
        `BMIU_OP_TEST:  dec.op = bmiu_test_e;
        default:        dec.op = bmiu_none_e;
      endcase
    end
  end
endmodule : bmiu_decode
`default_nettype wire

// ---- tb/bmiu_props.sv ----
// port checker for the bit instruction executor
`default_nettype none
module bmiu_props (
  input wire logic               sys_clk,
  input wire logic               nrst,
  input wire logic               instr_valid,
  input wire logic [13:0]        instr_word,
  input wire logic [7:0]         rf_rdata,
  input wire bmiu_pkg::bmiu_rf_t rf_r,
  input wire logic               phase_q1_r,
  input wire logic               busy_r,
  input wire logic               skip_r,
  input wire logic               no_operation_r,
  input wire logic               done_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  read_on_take_a: assert property (
    phase_q1_r && instr_valid && instr_word[13:12] == 2'h1 &&
    instr_word[11:10] != 2'h3 |=>
    rf_r.rd_en && rf_r.addr == $past(instr_word[6:0]))
    else $error("no read");
  four_phase_a: assert property (
    rf_r.rd_en |-> ##3 (done_r || skip_r))
    else $error("instruction not closed at phase four");
  write_done_a: assert property (rf_r.wr_en |-> done_r)
    else $error("write outside final phase");
  skip_nop_a: assert property (
    skip_r |-> no_operation_r[*4] ##1 done_r)
    else $error("skip cycle wrong");
  quiet_nop_a: assert property (
    no_operation_r |-> !rf_r.wr_en && !rf_r.rd_en)
    else $error("access in skip cycle");
  busy_refuse_a: assert property (busy_r |=> !rf_r.rd_en)
    else $error("word taken while busy");
  bit_value_a: assert property (
    rf_r.wr_en |-> rf_r.wdata[$past(instr_word[9:7], 4)] ==
    $past(instr_word[10], 4)) else $error("bad bit");
  other_bits_a: assert property (
    rf_r.wr_en |-> $countones(rf_r.wdata ^ $past(rf_rdata, 3)) <= 1)
    else $error("byte lost");
endmodule : bmiu_props
bind bmiu_core bmiu_props u_props (.sys_clk(sys_clk), .nrst(nrst),
  .instr_valid(instr_valid), .instr_word(instr_word), .rf_rdata(rf_rdata),
  .rf_r(rf_r), .phase_q1_r(phase_q1_r), .busy_r(busy_r), .skip_r(skip_r),
  .no_operation_r(no_operation_r), .done_r(done_r));
`default_nettype wire

// ---- tb/bmiu_rf_model.sv ----
// register file stand-in answering the read and write pulses
`default_nettype none
module bmiu_rf_model (
  input  wire logic               sys_clk,
  input  wire bmiu_pkg::bmiu_rf_t rf,
  output logic [7:0]              rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [128];
  // data only holds while read is asked, so a late sample shows up wrong
  assign rdata = rf.rd_en ? mem[rf.addr] : ~mem[rf.addr];
  // the whole byte comes back in the last phase
  always @(posedge sys_clk) if (rf.wr_en) mem[rf.addr] <= rf.wdata;
endmodule : bmiu_rf_model
`default_nettype wire

// ---- tb/bmiu_core_test.sv ----
// self-checking bench for the bit instruction executor
`default_nettype none
module bmiu_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import bmiu_pkg::*;
  typedef struct {logic [13:0] w; logic [7:0] pre, exp; logic sk;} bmiu_row_t;
  logic        sys_clk = 0, nrst = 0, instr_valid = 0, sk, dn;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0]  rf_rdata;
  bmiu_rf_t    rf_r;
  logic        phase_q1_r, busy_r, skip_r, no_operation_r, done_r;
  int          fail_count = 0, n_tests = 0;
  bmiu_row_t   rows [6] = '{'{14'h1385, 8'hc7, 8'h47, 0},
    '{14'h17ff, 8'h0a, 8'h8a, 0}, '{14'h1000, 8'hff, 8'hfe, 0},
    '{14'h1401, 8'h00, 8'h01, 0}, '{14'h1890, 8'h02, 8'h02, 0},
    '{14'h1890, 8'hfd, 8'hfd, 1}};
  bmiu_core u_bmiu_core (.sys_clk(sys_clk), .nrst(nrst),
    .instr_valid(instr_valid), .instr_word(instr_word), .rf_rdata(rf_rdata),
    .rf_r(rf_r), .phase_q1_r(phase_q1_r), .busy_r(busy_r), .skip_r(skip_r),
    .no_operation_r(no_operation_r), .done_r(done_r));
  bmiu_rf_model u_bmiu_rf_model (.sys_clk(sys_clk), .rf(rf_r),
    .rdata(rf_rdata));
  task automatic check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // offer one word, then wait a bounded time for the end pulse
  task automatic run(input logic [13:0] w);
    int n;
    sk = 0;
    n = 0;
    @(posedge sys_clk) instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge sys_clk) instr_valid <= 1'b0;
    #1;
    while (done_r !== 1'b1 && n < 12) begin
      @(posedge sys_clk) #1;
      n++;
      if (skip_r === 1'b1) sk = 1;
    end
    dn = (done_r === 1'b1);
    // the write lands on the edge after done, so let it pass
    @(posedge sys_clk) #1;
  endtask : run
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial forever #50 sys_clk = ~sys_clk;
  // whole run is near 100 cycles, so 1000 is ample
  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end
  initial begin
    @(posedge sys_clk);
    #1 check({rf_r, phase_q1_r, busy_r, skip_r, no_operation_r, done_r},
      32'h10);
    @(posedge sys_clk) nrst <= 1'b1;
    foreach (rows[i]) begin
      u_bmiu_rf_model.mem[rows[i].w[6:0]] = rows[i].pre;
      run(rows[i].w);
      check(u_bmiu_rf_model.mem[rows[i].w[6:0]], rows[i].exp);
      check({dn, sk}, {1'b1, rows[i].sk});
    end
    // opcode 11 and a non-bit class must be ignored
    u_bmiu_rf_model.mem[3] = 8'h5a;
    run(14'h1f83);
    check({dn, u_bmiu_rf_model.mem[3]}, 32'h05a);
    run(14'h0383);
    check({dn, u_bmiu_rf_model.mem[3]}, 32'h05a);
    // a word held up from q2 into the first empty phase of a skip must be dropped
    u_bmiu_rf_model.mem[16] = 8'hfd;
    u_bmiu_rf_model.mem[5] = 8'h00;
    @(posedge sys_clk) instr_valid <= 1'b1;
    instr_word <= 14'h1890;
    @(posedge sys_clk) instr_word <= 14'h1785;
    repeat (3) @(posedge sys_clk);
    #1 check({phase_q1_r, busy_r, skip_r, no_operation_r},
      32'h7);
    @(posedge sys_clk) instr_valid <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 check({phase_q1_r, u_bmiu_rf_model.mem[5]}, 32'h100);
    // reset in the middle of a set must stop the write
    u_bmiu_rf_model.mem[2] = 8'h00;
    @(posedge sys_clk) instr_valid <= 1'b1;
    instr_word <= 14'h1402;
    @(posedge sys_clk) instr_valid <= 1'b0;
    @(posedge sys_clk) nrst <= 1'b0;
    #1 check({rf_r, phase_q1_r, busy_r, skip_r, no_operation_r, done_r},
      32'h10);
    @(posedge sys_clk) nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check(u_bmiu_rf_model.mem[2], 8'h00);
    run(14'h1402);
    check(u_bmiu_rf_model.mem[2], 8'h01);
    give_verdict;
  end
endmodule : bmiu_core_test
`default_nettype wire
